// ### cbu_carry_bit_unit.sv
`timescale 1ns/1ps
module cbu_carry_bit_unit
  import cbu_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // instruction from the decoder
  input  wire cbu_req_type       req,
  // results
  output cbu_rsp_type            rsp,
  output logic [NIB_W-1:0]       accumulator,
  output logic                   carry_flag,
  output logic                   skipping
);

  // ==========================================================================
  // state
  logic [NIB_W-1:0] acc_q, acc_d;
  logic             carry_q, carry_d;
  cbu_rsp_type      rsp_q, rsp_d;
  cbu_state_type    state_q, state_d;

  // ==========================================================================
  // decode
  // an instruction acts only in the run state; a pending skip eats it whole
  logic             run_st;
  logic             act;
  logic             swallow;
  logic             do_setc;
  logic             do_clrc;
  logic             do_skipc;
  logic             do_cmpl;
  logic             do_rotr;
  logic             do_bset;
  logic             do_bclr;
  logic             do_btest;
  logic             take_skip;
  logic             test_bit;
  logic [NIB_W-1:0] bit_hit;
  logic [NIB_W-1:0] set_nib;
  logic [NIB_W-1:0] clr_nib;

  always_comb
  begin
    run_st   = (state_q == CBU_RUN);
    act      = req.valid && run_st;
    swallow  = req.valid && (state_q == CBU_SKIP);
    do_setc  = 1'b0;
    do_clrc  = 1'b0;
    do_skipc = 1'b0;
    do_cmpl  = 1'b0;
    do_rotr  = 1'b0;
    do_bset  = 1'b0;
    do_bclr  = 1'b0;
    do_btest = 1'b0;
    if (act)
    begin
      case (req.op)
        CBU_OP_SETC:  do_setc  = 1'b1;
        CBU_OP_CLRC:  do_clrc  = 1'b1;
        CBU_OP_SKIPC: do_skipc = 1'b1;
        CBU_OP_CMPL:  do_cmpl  = 1'b1;
        CBU_OP_ROTR:  do_rotr  = 1'b1;
        CBU_OP_BSET:  do_bset  = 1'b1;
        CBU_OP_BCLR:  do_bclr  = 1'b1;
        CBU_OP_BTEST: do_btest = 1'b1;
        // no-op or an unused code: done pulse only
        default:      do_setc  = 1'b0;
      endcase
    end
    test_bit  = |(bit_hit & req.mem_rd);
    // carry is only read for the skip decision, never written here
    take_skip = (do_skipc && !carry_q) || (do_btest && !test_bit);
  end

  // ==========================================================================
  // per-bit select for the bit instructions
  // each bit keeps the pointed nibble's value unless it is the selected one
  // no dynamic index, so every bit is a small fixed gate
  for (genvar gi = 0; gi < NIB_W; gi++)
  begin : g_bit
    assign bit_hit[gi] = (req.bit_sel == BIT_SEL_W'(gi));
    assign set_nib[gi] = bit_hit[gi] | req.mem_rd[gi];
    assign clr_nib[gi] = ~bit_hit[gi] & req.mem_rd[gi];
  end

  // ==========================================================================
  // accumulator and carry
  // skip-on-carry and the bit ops never touch these
  always_comb
  begin
    acc_d   = acc_q;
    carry_d = carry_q;
    if (do_setc)
    begin
      carry_d = 1'b1;
    end
    if (do_clrc)
    begin
      carry_d = 1'b0;
    end
    if (do_cmpl)
    begin
      acc_d = ~acc_q;
    end
    if (do_rotr)
    begin
      // old carry in at the top, bit 0 out to carry
      acc_d   = {carry_q, acc_q[ACC_MSB:1]};
      carry_d = acc_q[0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      acc_q   <= ACC_RESET;
      carry_q <= CARRY_RESET;
    end
    else
    begin
      acc_q   <= acc_d;
      carry_q <= carry_d;
    end
  end

  // ==========================================================================
  // response to the sequencer and the data memory
  // every pulse lasts one cycle; one pulse per instruction word presented
  always_comb
  begin
    rsp_d = RSP_RESET;
    if (act)
    begin
      rsp_d.done      = 1'b1;
      rsp_d.mem_wdata = req.mem_rd;
    end
    if (do_bset)
    begin
      rsp_d.mem_we    = 1'b1;
      rsp_d.mem_wdata = set_nib;
    end
    if (do_bclr)
    begin
      rsp_d.mem_we    = 1'b1;
      rsp_d.mem_wdata = clr_nib;
    end
    if (take_skip)
    begin
      rsp_d.skip_next = 1'b1;
    end
    if (swallow)
    begin
      // skipped slot: done only, nothing written
      rsp_d.done = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      rsp_q <= RSP_RESET;
    end
    else
    begin
      rsp_q <= rsp_d;
    end
  end

  // ==========================================================================
  // skip state
  // decisions are only made in run, so skips never chain
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      CBU_RUN:
      begin
        if (take_skip)
        begin
          state_d = CBU_SKIP;
        end
      end
      CBU_SKIP:
      begin
        // the next fetched word is swallowed, then back to run
        if (req.valid)
        begin
          state_d = CBU_RUN;
        end
      end
      // an illegal code recovers without acting
      default: state_d = CBU_RUN;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_q <= CBU_RUN;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // outputs, all straight off flops
  assign rsp         = rsp_q;
  assign accumulator = acc_q;
  assign carry_flag  = carry_q;
  // one-hot skip bit of the state register, no decode in the path
  assign skipping    = state_q[1];

endmodule // cbu_carry_bit_unit

// ### cbu_pkg.sv
// Operation
// - set-carry forces the carry flag to one whatever it held before.
// - clear-carry forces the carry flag to zero whatever it held before.
// - skip-on-carry skips the next instruction when carry is zero and runs it when carry is one.
// - skip-on-carry leaves the carry flag unchanged, skip taken or not.
// - complement inverts all four accumulator bits and writes them back.
// - rotate shifts the accumulator right through carry, old carry into bit 3, bit 0 into carry.
// - bit-set writes one into immediate-selected bit j (0 to 3) of the pointed nibble only.
// - bit-clear writes zero into the selected bit of the pointed nibble, other bits unchanged.
// - bit-test skips the next instruction when the selected bit of the pointed nibble is zero.
package cbu_pkg;

  // ==========================================================================
  // widths and reset values
  localparam int          NIB_W       = 4;
  localparam int          BIT_SEL_W   = 2;
  localparam logic [3:0]  ACC_RESET   = 4'h0;
  localparam logic        CARRY_RESET = 1'b0;
  localparam int          ACC_MSB     = 3;

  // ==========================================================================
  // operation codes from the decoder
  typedef enum logic [3:0] {
    CBU_OP_NONE   = 4'h0,
    CBU_OP_SETC   = 4'h1,
    CBU_OP_CLRC   = 4'h2,
    CBU_OP_SKIPC  = 4'h3,
    CBU_OP_CMPL   = 4'h4,
    CBU_OP_ROTR   = 4'h5,
    CBU_OP_BSET   = 4'h6,
    CBU_OP_BCLR   = 4'h7,
    CBU_OP_BTEST  = 4'h8
  } cbu_op_type;

  typedef struct packed {
    logic                 valid;
    cbu_op_type           op;
    logic [BIT_SEL_W-1:0] bit_sel;
    logic [NIB_W-1:0]     mem_rd;
  } cbu_req_type;

  typedef struct packed {
    logic             mem_we;
    logic [NIB_W-1:0] mem_wdata;
    logic             skip_next;
    logic             done;
  } cbu_rsp_type;

  localparam cbu_rsp_type RSP_RESET = '{mem_we: 1'b0, mem_wdata: 4'h0,
                                        skip_next: 1'b0, done: 1'b0};

  // skip state: one-hot
  typedef enum logic [1:0] {
    CBU_RUN  = 2'b01,
    CBU_SKIP = 2'b10
  } cbu_state_type;

endpackage

// ### cbu_chk.sv
`timescale 1ns/1ps
module cbu_chk
  import cbu_pkg::*;
(
  input wire logic             sys_clk,
  input wire logic             reset,
  input wire cbu_req_type      req,
  input wire cbu_rsp_type      rsp,
  input wire logic [NIB_W-1:0] accumulator,
  input wire logic             carry_flag,
  input wire logic             skipping
);
  // a swallowed instruction counts as no operation
  wire cbu_op_type o = (req.valid && !skipping) ? req.op : CBU_OP_NONE;
  wire logic [3:0] m = 4'h1 << req.bit_sel;
  wire logic       b = req.mem_rd[req.bit_sel];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_carry_set: assert property (o == CBU_OP_SETC |=> carry_flag) else $error("no set");
  a_carry_clear: assert property (o == CBU_OP_CLRC |=> !carry_flag) else $error("no clr");
  a_carry_skip: assert property (o == CBU_OP_SKIPC
    |=> rsp.skip_next != $past(carry_flag) && $stable(carry_flag)) else $error("bad skip");
  a_acc_invert: assert property (o == CBU_OP_CMPL |=> accumulator == ~$past(accumulator))
    else $error("bad cmpl");
  a_acc_rotate: assert property (o == CBU_OP_ROTR
    |=> {accumulator, carry_flag} == {$past(carry_flag), $past(accumulator)}) else $error("bad rot");
  a_bit_set: assert property (o == CBU_OP_BSET
    |=> rsp.mem_we && rsp.mem_wdata == ($past(req.mem_rd) | $past(m))) else $error("bad bset");
  a_bit_clear: assert property (o == CBU_OP_BCLR
    |=> rsp.mem_we && rsp.mem_wdata == ($past(req.mem_rd) & ~$past(m))) else $error("bad bclr");
  a_bit_test: assert property (o == CBU_OP_BTEST |=> rsp.skip_next != $past(b))
    else $error("bad test");
  a_skip_swallow: assert property (req.valid && skipping
    |=> rsp.done && !rsp.mem_we && !rsp.skip_next && !skipping && $stable(accumulator)
      && $stable(carry_flag)) else $error("bad swallow");
endmodule // cbu_chk
bind cbu_carry_bit_unit cbu_chk cbu_chk_i (.sys_clk(sys_clk), .reset(reset), .req(req), .rsp(rsp),
  .accumulator(accumulator), .carry_flag(carry_flag), .skipping(skipping));

// ### cbu_mem_model.sv
`timescale 1ns/1ps
module cbu_mem_model
  import cbu_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire cbu_rsp_type rsp,
  output logic [3:0]       mem_rd
);
  logic [3:0] mem_q;
  // forward the pending write so back-to-back bit ops see it
  assign mem_rd = rsp.mem_we ? rsp.mem_wdata : mem_q;
  always_ff @(posedge sys_clk) mem_q <= reset ? 4'h0 : mem_rd;
endmodule // cbu_mem_model

// ### test_carry_and_bit_ops_unit.sv
`timescale 1ns/1ps
module test_carry_and_bit_ops_unit;
  import cbu_pkg::*;
  logic        sys_clk = 1'b0, reset = 1'b1, v = 1'b0, c = 1'b0, k = 1'b0, cy, sk_o, we, sk;
  cbu_op_type  op = CBU_OP_NONE, o;
  logic [1:0]  bs = 2'h0, s;
  logic [3:0]  mem_rd, acc, a = 4'h0, m = 4'h0, wd;
  cbu_rsp_type rsp;
  cbu_req_type req;
  int          mismatches = 0, n_compared = 0;
  logic [15:0] q[$];
  assign req = '{valid: v, op: op, bit_sel: bs, mem_rd: mem_rd};
  always #25 sys_clk = ~sys_clk;
  cbu_carry_bit_unit cbu_carry_bit_unit_i (.sys_clk(sys_clk), .reset(reset), .req(req),
    .rsp(rsp), .accumulator(acc), .carry_flag(cy), .skipping(sk_o));
  cbu_mem_model cbu_mem_model_i (.sys_clk(sys_clk), .reset(reset), .rsp(rsp), .mem_rd(mem_rd));
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk)
    if (!reset && rsp.done === 1'b1)
      check("rsp", {acc, cy, rsp.mem_we, rsp.mem_we ? rsp.mem_wdata : 4'h0, rsp.skip_next, sk_o},
        q.size() ? q.pop_front() : 16'hffff);
  initial
  begin
    #100000;
    mismatches++;
    finish_test;
  end
  initial
  begin
    void'($urandom(79));
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1 check("reset", {acc, cy, sk_o, rsp}, 16'h0);
    $display("test reset done");
    repeat (400)
    begin
      @(posedge sys_clk);
      o = cbu_op_type'($urandom_range(0, 8));
      s = 2'($urandom_range(0, 3));
      v <= 1'b1;
      op <= o;
      bs <= s;
      we = 1'b0;
      wd = 4'h0;
      sk = 1'b0;
      if (!k)
        case (o)
          CBU_OP_SETC: c = 1'b1;
          CBU_OP_CLRC: c = 1'b0;
          CBU_OP_SKIPC: sk = !c;
          CBU_OP_CMPL: a = ~a;
          CBU_OP_ROTR: {a, c} = {c, a};
          CBU_OP_BSET: {we, wd} = {1'b1, m | (4'h1 << s)};
          CBU_OP_BCLR: {we, wd} = {1'b1, m & ~(4'h1 << s)};
          CBU_OP_BTEST: sk = !m[s];
          default: ;
        endcase
      if (we) m = wd;
      k = sk;
      q.push_back({4'h0, a, c, we, wd, sk, sk});
    end
    @(posedge sys_clk);
    v <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("queue", 16'(q.size()), 16'h0);
    $display("test random done");
    finish_test;
  end
endmodule // test_carry_and_bit_ops_unit
